//--- hw/timer_pkg.sv
// constants shared by the prescaled 8/16-bit timer counter
package timer_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_LOW = 12'h004;
  localparam logic [11:0] OFF_HIGH = 12'h008;
  localparam logic [11:0] OFF_IRQ = 12'h00C;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_RUN = 7;
  localparam int CTRL_WIDTH = 6;
  localparam int CTRL_SRC = 5;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_BYP = 3;
  localparam int CTRL_PS_LSB = 0;
  localparam int CTRL_PS_W = 3;
  localparam int IRQ_IE = 5;
  localparam int IRQ_FLAG = 2;
  localparam logic [7:0] CTRL_RST = 8'hFF;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] HIGH_RST = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;

  // ****************************************
  // timing
  // ****************************************
  // instruction cycle is four input clocks
  localparam logic [1:0] CYCLE_LAST = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

endpackage

//--- hw/timer_counter.sv
// prescaled 8/16-bit timer counter with apb register access
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module timer_counter import timer_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic sleep_mode,
  input wire logic external_clock_pin,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic overflow_irq
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFF_CTRL) | hit(a, OFF_LOW) | hit(a, OFF_HIGH) | hit(a, OFF_IRQ);
  endfunction

  // low bits of the prescaler that must all be ones for an output pulse
  function automatic logic [7:0] ps_mask(input logic [2:0] ps);
    ps_mask = BYTE_ONES >> (3'h7 - ps);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [7:0] buf_q;
  logic [7:0] pre_q;
  logic [1:0] div_q;
  logic [1:0] inhibit_q;
  logic [2:0] sync_q;
  logic pin_lvl_q;
  logic pin_prev_q;
  logic flag_q;
  logic ie_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  logic setup;
  logic done;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic wr_irq;
  logic rd_low;
  logic cyc_en;
  logic rise;
  logic fall;
  logic ext_edge;
  logic src_tick;
  logic gate;
  logic pre_out;
  logic tick;
  logic ovf;
  logic [7:0] rd_byte;
  logic [7:0] mask;
  logic [15:0] word;
  logic [15:0] word_inc;

  logic run_enable;
  logic width_select;
  logic source_select;
  logic edge_select;
  logic prescaler_bypass;
  logic [2:0] prescale_field;

  assign run_enable = ctrl_q[CTRL_RUN];
  assign width_select = ctrl_q[CTRL_WIDTH];
  assign source_select = ctrl_q[CTRL_SRC];
  assign edge_select = ctrl_q[CTRL_EDGE];
  assign prescaler_bypass = ctrl_q[CTRL_BYP];
  assign prescale_field = ctrl_q[CTRL_PS_LSB +: CTRL_PS_W];

  // ****************************************
  // apb decode
  // ****************************************
  assign setup = psel & ~penable;
  assign done = psel & penable & pready_q;
  // unmapped or lane-less writes change nothing
  assign wr_ok = done & pwrite & ~pslverr_q & pstrb[0];
  assign wr_ctrl = wr_ok & hit(paddr, OFF_CTRL);
  assign wr_low = wr_ok & hit(paddr, OFF_LOW);
  assign wr_high = wr_ok & hit(paddr, OFF_HIGH);
  assign wr_irq = wr_ok & hit(paddr, OFF_IRQ);
  // read side effect lands on the same edge that samples the low byte
  assign rd_low = setup & ~pwrite & hit(paddr, OFF_LOW);

  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr, OFF_CTRL)) begin
      rd_byte = ctrl_q;
    end else if (hit(paddr, OFF_LOW)) begin
      rd_byte = low_q;
    end else if (hit(paddr, OFF_HIGH)) begin
      rd_byte = buf_q;
    end else if (hit(paddr, OFF_IRQ)) begin
      rd_byte[IRQ_IE] = ie_q;
      rd_byte[IRQ_FLAG] = flag_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped(paddr);
      if (setup) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ****************************************
  // instruction cycle divider
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (div_q == CYCLE_LAST) ? 2'h0 : div_q + 2'h1;
    end
  end

  assign cyc_en = (div_q == CYCLE_LAST);

  // ****************************************
  // external pin synchroniser
  // ****************************************
  // a level is taken only once two stages agree, so one glitch is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
      pin_lvl_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], external_clock_pin};
      if (sync_q[1] == sync_q[2]) begin
        pin_lvl_q <= sync_q[2];
      end
      pin_prev_q <= pin_lvl_q;
    end
  end

  assign rise = pin_lvl_q & ~pin_prev_q;
  assign fall = ~pin_lvl_q & pin_prev_q;
  assign ext_edge = edge_select ? fall : rise;

  // ****************************************
  // clock selection and prescaler
  // ****************************************
  assign src_tick = source_select ? ext_edge : cyc_en;
  assign gate = run_enable & ~sleep_mode;
  assign mask = ps_mask(prescale_field);
  assign pre_out = src_tick & ((pre_q & mask) == mask);

  // settings are read live each cycle, so reassignment needs no stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 8'h00;
    end else if (wr_low && !prescaler_bypass) begin
      pre_q <= 8'h00;
    end else if (src_tick && gate && !prescaler_bypass) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // ****************************************
  // write inhibit
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_q <= 2'h0;
    end else if (wr_low) begin
      inhibit_q <= INHIBIT_CYCLES;
    end else if (cyc_en && inhibit_q != 2'h0) begin
      inhibit_q <= inhibit_q - 2'h1;
    end
  end

  assign tick = gate & (prescaler_bypass ? src_tick : pre_out) & (inhibit_q == 2'h0);

  // ****************************************
  // count registers
  // ****************************************
  assign word = {high_q, low_q};
  assign word_inc = word + 16'h0001;
  assign ovf = tick & ~wr_low & (width_select ? (low_q == BYTE_ONES) : (word == WORD_ONES));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= LOW_RST;
      high_q <= HIGH_RST;
    end else if (wr_low) begin
      low_q <= pwdata[7:0];
      if (!width_select) begin
        high_q <= buf_q;
      end
    end else if (tick) begin
      if (width_select) begin
        low_q <= low_q + 8'h01;
      end else begin
        low_q <= word_inc[7:0];
        high_q <= word_inc[15:8];
      end
    end
  end

  // ****************************************
  // high byte buffer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= HIGH_RST;
    end else if (wr_high) begin
      buf_q <= pwdata[7:0];
    end else if (rd_low && !width_select) begin
      buf_q <= high_q;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // ****************************************
  // overflow flag and request
  // ****************************************
  // never cleared by hardware; a wrap in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (ovf) begin
      flag_q <= 1'b1;
    end else if (wr_irq) begin
      flag_q <= pwdata[IRQ_FLAG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
    end else if (wr_irq) begin
      ie_q <= pwdata[IRQ_IE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q & ie_q;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign overflow_irq = irq_q;

endmodule

//--- dv/timer_asserts.sv
// port checker for the timer counter
`timescale 1ns/1ps
module timer_asserts import timer_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic sleep_mode,
  input wire logic external_clock_pin,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic overflow_irq
);
  // ****************************************
  // bus and interrupt properties
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire done = psel && penable && pready;
  wire mapped = paddr inside {OFF_CTRL, OFF_LOW, OFF_HIGH, OFF_IRQ};
  AST_READY_ONE: assert property (setup |=> pready) else $error("no ready after setup");
  AST_READY_ONLY: assert property (pready |-> $past(setup) && penable) else $error("stray ready");
  AST_ERR_UNMAPPED: assert property (setup && !mapped |=> pslverr) else $error("no error");
  AST_OK_MAPPED: assert property (setup && mapped |=> !pslverr) else $error("false error");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper bits");
  AST_UNMAPPED_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("data");
  // mask takes one cycle to land, then the registered request one more
  AST_IRQ_MASK: assert property (done && pwrite && pstrb[0] && paddr == OFF_IRQ &&
    !pwdata[IRQ_IE] |-> ##2 !overflow_irq) else $error("request not masked");
  AST_IRQ_FLAG: assert property (pready && !pwrite && paddr == OFF_IRQ && overflow_irq
    |-> prdata[IRQ_IE] && prdata[IRQ_FLAG]) else $error("request without flag");
  cover property (done && pwrite && paddr == OFF_LOW);
  cover property ($rose(overflow_irq));
  cover property (setup && !mapped);
endmodule

//--- dv/tb_top.sv
// self-checking bench for the timer counter
`timescale 1ns/1ps
module tb_top import timer_pkg::*;;
  // ****************************************
  // bench
  // ****************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0, ext_pin = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, keep;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, overflow_irq, serr;
  int err_total = 0, n_tests = 0;
  timer_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .sleep_mode(sleep_mode),
    .external_clock_pin(ext_pin), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overflow_irq(overflow_irq));
  initial forever #2.5 pclk = ~pclk;
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h..%h", $time, g, lo, hi);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk(1, 0, 0);
      report_and_stop;
    end
    r = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse;
    ext_pin <= 1;
    cyc(8);
    ext_pin <= 0;
    cyc(8);
  endtask
  task t_reset;
    apb(0, OFF_CTRL, 0);
    chk(r, CTRL_RST, CTRL_RST);
    apb(0, OFF_HIGH, 0);
    chk(r, HIGH_RST, HIGH_RST);
    apb(0, OFF_IRQ, 0);
    chk(r, 0, 0);
    apb(0, 12'h010, 0);
    chk(serr, 1, 1);
    chk(r, 0, 0);
    $display("reset test done");
  endtask
  task t_run;
    apb(1, OFF_CTRL, 8'h48);
    apb(0, OFF_LOW, 0);
    keep = r;
    pstrb <= 4'h0;
    apb(1, OFF_CTRL, 8'hC8);
    pstrb <= 4'hF;
    apb(0, OFF_CTRL, 0);
    chk(r, 8'h48, 8'h48);
    cyc(40);
    apb(0, OFF_LOW, 0);
    chk(r, keep, keep);
    $display("run test done");
  endtask
  task t_timer;
    apb(1, OFF_CTRL, 8'hC8);
    apb(1, OFF_LOW, 0);
    cyc(160);
    apb(0, OFF_LOW, 0);
    chk(r, 37, 39);
    $display("timer test done");
  endtask
  task t_presc;
    // no stop between codes: assignment changes while running
    for (int ps = 0; ps < 8; ps++) begin
      apb(1, OFF_CTRL, 8'hC0 | ps[7:0]);
      apb(1, OFF_LOW, 0);
      cyc(12 * (2 << ps));
      apb(0, OFF_LOW, 0);
      chk(r, 2, 3);
    end
    $display("prescaler test done");
  endtask
  task t_wrap16;
    apb(1, OFF_CTRL, 8'h88);
    apb(1, OFF_IRQ, 8'h20);
    apb(1, OFF_HIGH, 8'hFF);
    apb(1, OFF_LOW, 8'hF0);
    cyc(100);
    chk(overflow_irq, 1, 1);
    apb(0, OFF_LOW, 0);
    chk(r, 5, 9);
    apb(0, OFF_HIGH, 0);
    chk(r, 0, 0);
    apb(0, OFF_IRQ, 0);
    chk(r, 8'h24, 8'h24);
    apb(1, OFF_IRQ, 8'h04);
    cyc(2);
    chk(overflow_irq, 0, 0);
    apb(1, OFF_IRQ, 8'h00);
    apb(0, OFF_IRQ, 0);
    chk(r, 0, 0);
    apb(1, OFF_HIGH, 8'h12);
    apb(1, OFF_LOW, 8'h00);
    // a fresh buffer value must not reach the live byte without a low write
    apb(1, OFF_HIGH, 8'h34);
    apb(0, OFF_LOW, 0);
    apb(0, OFF_HIGH, 0);
    chk(r, 8'h12, 8'h12);
    $display("16-bit test done");
  endtask
  task t_wrap8;
    apb(1, OFF_HIGH, 8'h5A);
    apb(1, OFF_IRQ, 8'h00);
    apb(1, OFF_CTRL, 8'hC8);
    apb(1, OFF_LOW, 8'hF8);
    cyc(60);
    apb(0, OFF_IRQ, 0);
    chk(r, 8'h04, 8'h04);
    apb(0, OFF_LOW, 0);
    chk(r, 4, 8);
    apb(0, OFF_HIGH, 0);
    chk(r, 8'h5A, 8'h5A);
    $display("8-bit test done");
  endtask
  task t_ext;
    apb(1, OFF_CTRL, 8'hE8);
    apb(1, OFF_LOW, 0);
    cyc(16);
    repeat (5) pulse;
    apb(0, OFF_LOW, 0);
    chk(r, 5, 5);
    apb(1, OFF_CTRL, 8'hF8);
    apb(1, OFF_LOW, 0);
    cyc(16);
    repeat (3) pulse;
    apb(0, OFF_LOW, 0);
    chk(r, 3, 3);
    $display("external test done");
  endtask
  task t_sleep;
    apb(1, OFF_CTRL, 8'hC8);
    sleep_mode <= 1;
    cyc(4);
    apb(0, OFF_LOW, 0);
    keep = r;
    cyc(40);
    apb(0, OFF_LOW, 0);
    chk(r, keep, keep);
    sleep_mode <= 0;
    presetn <= 0;
    cyc(5);
    presetn <= 1;
    apb(0, OFF_CTRL, 0);
    chk(r, CTRL_RST, CTRL_RST);
    $display("sleep test done");
  endtask
  initial begin
    cyc(5);
    presetn <= 1;
    t_reset;
    t_run;
    t_timer;
    t_presc;
    t_wrap16;
    t_wrap8;
    t_ext;
    t_sleep;
    report_and_stop;
  end
endmodule
bind timer_counter timer_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .sleep_mode(sleep_mode), .external_clock_pin(external_clock_pin), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .overflow_irq(overflow_irq));
